/* File: core/isr_pkg.sv */
// package: register map, field positions and carrier types of the interrupt router
package isr_pkg;

    localparam int NUM_SRC = 24;
    localparam int NUM_DST = 4;

    // ------------------------------------------------------------
    // source bit positions
    // ------------------------------------------------------------
    localparam int SRC_PORT_MODULE_AGGREGATE = 0;
    localparam int SRC_EXTERNAL_INPUT_ZERO = 1;
    localparam int SRC_EXTERNAL_INPUT_ONE = 2;
    localparam int SRC_TIMER_IRQ_A = 3;
    localparam int SRC_TIMER_IRQ_B = 4;
    localparam int SRC_TIMER_IRQ_C = 5;
    localparam int SRC_FIRST_SERIAL_PORT_IRQ = 6;
    localparam int SRC_SECOND_SERIAL_PORT_IRQ = 7;
    localparam int SRC_TWO_WIRE_IRQ = 8;
    localparam int SRC_SERIAL_MASTER_IRQ = 9;
    localparam int SRC_SOFTWARE_IRQ_A = 10;
    localparam int SRC_SOFTWARE_IRQ_B = 11;
    localparam int SRC_SERIAL_PIN_IRQ = 12;
    localparam int SRC_PARALLEL_PIN_IRQ = 13;
    localparam int SRC_MGMT_IFACE_IRQ_A = 14;
    localparam int SRC_MGMT_IFACE_IRQ_B = 15;
    localparam int SRC_FRAME_DMA_IRQ = 16;
    localparam int SRC_FRAME_ANALYZER_IRQ = 17;
    localparam int SRC_TIMESTAMP_READY_IRQ = 18;
    localparam int SRC_TIME_SYNC_IRQ = 19;
    localparam int SRC_MEMORY_INTEGRITY_IRQ = 20;
    localparam int SRC_EXTRACTION_READY_IRQ = 21;
    localparam int SRC_INJECTION_READY_IRQ = 22;
    localparam int SRC_PCIE_IRQ = 23;

    // ------------------------------------------------------------
    // destination replication indices
    // ------------------------------------------------------------
    localparam int DST_CORE_IRQ_LINE_A = 0;
    localparam int DST_CORE_IRQ_LINE_B = 1;
    localparam int DST_EXTERNAL_OUTPUT_ZERO = 2;
    localparam int DST_EXTERNAL_OUTPUT_ONE = 3;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SOURCE_RAW_VECTOR = 8'h00;
    localparam logic [7:0] OFS_SOURCE_NONSTICKY_SELECT = 8'h04;
    localparam logic [7:0] OFS_SOURCE_DETECT_MODE_LO = 8'h08;
    localparam logic [7:0] OFS_SOURCE_DETECT_MODE_HI = 8'h0C;
    localparam logic [7:0] OFS_SOURCE_EVENT_INJECT = 8'h10;
    localparam logic [7:0] OFS_SOURCE_LATCHED_EVENT = 8'h14;
    localparam logic [7:0] OFS_SOURCE_ENABLE_VECTOR = 8'h18;
    localparam logic [7:0] OFS_ENABLE_ATOMIC_CLEAR = 8'h1C;
    localparam logic [7:0] OFS_ENABLE_ATOMIC_SET = 8'h20;
    localparam logic [7:0] OFS_SOURCE_ACTIVE_VIEW = 8'h24;
    localparam logic [7:0] OFS_DESTINATION_SOURCE_MASK = 8'h28;
    localparam logic [7:0] OFS_DESTINATION_ACTIVE_VIEW = 8'h38;
    localparam logic [7:0] OFS_DEST_STRIDE = 8'h04;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [NUM_SRC-1:0] RST_VECTOR = 24'h000000;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // ------------------------------------------------------------
    // detect mode encoding, two bits per source
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ISR_LEVEL = 2'b00,
        ISR_ANY_EDGE = 2'b01,
        ISR_FALL_EDGE = 2'b10,
        ISR_RISE_EDGE = 2'b11
    } isr_mode_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } isr_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } isr_apb_rsp_s;

    typedef struct packed {
        logic [NUM_SRC-1:0] nonsticky;
        logic [2*NUM_SRC-1:0] mode;
        logic [NUM_SRC-1:0] latched;
        logic [NUM_SRC-1:0] enable;
        logic [NUM_DST*NUM_SRC-1:0] dmask;
    } isr_cfg_s;

endpackage : isr_pkg

/* File: core/isr_detect.sv */
// source event detector: synchroniser, edge and level detection, latched event bits
module isr_detect (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [isr_pkg::NUM_SRC-1:0] src_in,
    input wire logic [2*isr_pkg::NUM_SRC-1:0] mode,
    input wire logic [isr_pkg::NUM_SRC-1:0] inject,
    input wire logic [isr_pkg::NUM_SRC-1:0] clear,
    output logic [isr_pkg::NUM_SRC-1:0] raw,
    output logic [isr_pkg::NUM_SRC-1:0] latched
);

    typedef struct packed {
        logic [isr_pkg::NUM_SRC-1:0] s1;
        logic [isr_pkg::NUM_SRC-1:0] s2;
        logic [isr_pkg::NUM_SRC-1:0] s3;
        logic [isr_pkg::NUM_SRC-1:0] stable;
        logic [isr_pkg::NUM_SRC-1:0] latched;
    } isr_det_s;

    isr_det_s st_r;
    isr_det_s st_nxt;
    logic [isr_pkg::NUM_SRC-1:0] hit;

    // ------------------------------------------------------------
    // detection
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        hit = '0;
        st_nxt.s1 = src_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < isr_pkg::NUM_SRC; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.stable[i] = st_r.s3[i];
            end
            case (isr_pkg::isr_mode_e'(mode[2*i +: 2]))
                isr_pkg::ISR_LEVEL: hit[i] = st_r.stable[i]; // R23
                isr_pkg::ISR_ANY_EDGE: hit[i] = st_nxt.stable[i] != st_r.stable[i]; // R24
                isr_pkg::ISR_FALL_EDGE: hit[i] = st_r.stable[i] & ~st_nxt.stable[i]; // R24
                isr_pkg::ISR_RISE_EDGE: hit[i] = ~st_r.stable[i] & st_nxt.stable[i]; // R24
                default: hit[i] = 1'b0;
            endcase
        end
        // set wins over a software clear
        st_nxt.latched = (st_r.latched & ~clear) | hit | inject; // R25 R17
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= '0; // R27
        end else begin
            st_r <= st_nxt;
        end
    end

    assign raw = st_r.stable; // R16
    assign latched = st_r.latched;

endmodule : isr_detect

/* File: core/isr_router.sv */
// interrupt source router: 24 active-high sources to four destinations, APB registers
// Operation
// R1 - route all sources to four destinations
// R2 - two core lines, two external outputs
// R3 - destination indices core a,b, ext 0,1
// R4 - bit 0 carries port module aggregate
// R5 - external inputs at bits 1 and 2
// R6 - timers at bits 3, 4, 5
// R7 - serial ports 6, 7; two-wire 8
// R8 - serial master 9; software 10, 11
// R9 - serial pins 12, parallel 13, mgmt 14
// R10 - mgmt b 15, dma 16, analyzer 17
// R11 - timestamp 18, sync 19, integrity 20
// R12 - extraction 21, injection 22, pcie 23
// R13 - everything inside is active high
// R14 - source polarity fixed before entry
// R15 - destination polarity fixed after exit
// R16 - raw vector shows unlatched inputs
// R17 - inject forces event like real one
// R18 - per-source level or edge detection
// R19 - nonsticky uses raw, ignores latch
// R20 - atomic set and clear of enables
// R21 - active view: latched and enabled
// R22 - per-destination view, output when nonzero
// R23 - level mode sets latch every cycle
// R24 - edge modes: any, falling, rising
// R25 - write one clears; reasserts immediately
// R26 - destination mask gates propagation
// R27 - reset clears all settings and latches
//
// The APB interface to the registers and the address map were chosen for this implementation.
module isr_router (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [isr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_module_aggregate,
    input wire logic external_input_zero,
    input wire logic external_input_one,
    input wire logic timer_irq_a,
    input wire logic timer_irq_b,
    input wire logic timer_irq_c,
    input wire logic first_serial_port_irq,
    input wire logic second_serial_port_irq,
    input wire logic two_wire_irq,
    input wire logic serial_master_irq,
    input wire logic software_irq_a,
    input wire logic software_irq_b,
    input wire logic serial_pin_irq,
    input wire logic parallel_pin_irq,
    input wire logic mgmt_iface_irq_a,
    input wire logic mgmt_iface_irq_b,
    input wire logic frame_dma_irq,
    input wire logic frame_analyzer_irq,
    input wire logic timestamp_ready_irq,
    input wire logic time_sync_irq,
    input wire logic memory_integrity_irq,
    input wire logic extraction_ready_irq,
    input wire logic injection_ready_irq,
    input wire logic pcie_irq,
    output logic core_irq_line_a,
    output logic core_irq_line_b,
    output logic external_output_zero,
    output logic external_output_one
);

    localparam int NS = isr_pkg::NUM_SRC;
    localparam int ND = isr_pkg::NUM_DST;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        isr_pkg::isr_cfg_s cfg;
        logic [NS-1:0] inject;
        logic [NS-1:0] clear;
        logic [31:0] rdata;
        logic [ND-1:0] dst_out;
    } isr_top_s;

    isr_top_s st_r;
    isr_top_s st_nxt;

    logic [NS-1:0] src_vec;
    logic [NS-1:0] raw;
    logic [NS-1:0] latched;
    logic [NS-1:0] effective;
    logic [NS-1:0] active_view;
    logic [ND*NS-1:0] dst_view;
    logic wr_en;
    logic rd_en;
    logic hit_map;
    logic [31:0] rd_val;

    function automatic logic [31:0] isr_widen(input logic [NS-1:0] v);
        isr_widen = {8'h00, v};
    endfunction : isr_widen

    function automatic logic isr_in_dst(
        input logic [isr_pkg::ADDR_W-1:0] a,
        input logic [isr_pkg::ADDR_W-1:0] base
    );
        isr_in_dst = (a >= base) && (a < base + 8'h10) && (a[1:0] == 2'b00);
    endfunction : isr_in_dst

    function automatic logic [1:0] isr_dst_idx(
        input logic [isr_pkg::ADDR_W-1:0] a,
        input logic [isr_pkg::ADDR_W-1:0] base
    );
        logic [isr_pkg::ADDR_W-1:0] d;
        d = a - base;
        isr_dst_idx = d[3:2];
    endfunction : isr_dst_idx

    // ------------------------------------------------------------
    // source vector assembly, all inputs active high
    // ------------------------------------------------------------
    always_comb begin
        src_vec = '0;
        src_vec[isr_pkg::SRC_PORT_MODULE_AGGREGATE] = port_module_aggregate; // R4 R13 R14
        src_vec[isr_pkg::SRC_EXTERNAL_INPUT_ZERO] = external_input_zero; // R5
        src_vec[isr_pkg::SRC_EXTERNAL_INPUT_ONE] = external_input_one; // R5
        src_vec[isr_pkg::SRC_TIMER_IRQ_A] = timer_irq_a; // R6
        src_vec[isr_pkg::SRC_TIMER_IRQ_B] = timer_irq_b; // R6
        src_vec[isr_pkg::SRC_TIMER_IRQ_C] = timer_irq_c; // R6
        src_vec[isr_pkg::SRC_FIRST_SERIAL_PORT_IRQ] = first_serial_port_irq; // R7
        src_vec[isr_pkg::SRC_SECOND_SERIAL_PORT_IRQ] = second_serial_port_irq; // R7
        src_vec[isr_pkg::SRC_TWO_WIRE_IRQ] = two_wire_irq; // R7
        src_vec[isr_pkg::SRC_SERIAL_MASTER_IRQ] = serial_master_irq; // R8
        src_vec[isr_pkg::SRC_SOFTWARE_IRQ_A] = software_irq_a; // R8
        src_vec[isr_pkg::SRC_SOFTWARE_IRQ_B] = software_irq_b; // R8
        src_vec[isr_pkg::SRC_SERIAL_PIN_IRQ] = serial_pin_irq; // R9
        src_vec[isr_pkg::SRC_PARALLEL_PIN_IRQ] = parallel_pin_irq; // R9
        src_vec[isr_pkg::SRC_MGMT_IFACE_IRQ_A] = mgmt_iface_irq_a; // R9
        src_vec[isr_pkg::SRC_MGMT_IFACE_IRQ_B] = mgmt_iface_irq_b; // R10
        src_vec[isr_pkg::SRC_FRAME_DMA_IRQ] = frame_dma_irq; // R10
        src_vec[isr_pkg::SRC_FRAME_ANALYZER_IRQ] = frame_analyzer_irq; // R10
        src_vec[isr_pkg::SRC_TIMESTAMP_READY_IRQ] = timestamp_ready_irq; // R11
        src_vec[isr_pkg::SRC_TIME_SYNC_IRQ] = time_sync_irq; // R11
        src_vec[isr_pkg::SRC_MEMORY_INTEGRITY_IRQ] = memory_integrity_irq; // R11
        src_vec[isr_pkg::SRC_EXTRACTION_READY_IRQ] = extraction_ready_irq; // R12
        src_vec[isr_pkg::SRC_INJECTION_READY_IRQ] = injection_ready_irq; // R12
        src_vec[isr_pkg::SRC_PCIE_IRQ] = pcie_irq; // R12
    end

    // ------------------------------------------------------------
    // detection
    // ------------------------------------------------------------
    isr_detect u_detect (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .src_in(src_vec),
        .mode(st_r.cfg.mode), // R18
        .inject(st_r.inject),
        .clear(st_r.clear),
        .raw(raw),
        .latched(latched)
    );

    // ------------------------------------------------------------
    // source and destination views
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NS; i++) begin
            effective[i] = st_r.cfg.nonsticky[i] ? raw[i] : latched[i]; // R19
        end
        active_view = effective & st_r.cfg.enable; // R21
        for (int d = 0; d < ND; d++) begin
            dst_view[d*NS +: NS] = active_view & st_r.cfg.dmask[d*NS +: NS]; // R22 R26 R1
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign wr_en = psel & penable & pwrite;
    // read data captured in setup, so it stands through access
    assign rd_en = psel & ~penable & ~pwrite;
    assign hit_map = isr_in_dst(paddr, isr_pkg::OFS_DESTINATION_SOURCE_MASK)
        || isr_in_dst(paddr, isr_pkg::OFS_DESTINATION_ACTIVE_VIEW)
        || (paddr <= isr_pkg::OFS_SOURCE_ACTIVE_VIEW && paddr[1:0] == 2'b00);

    always_comb begin
        rd_val = isr_pkg::RST_WORD;
        case (paddr)
            isr_pkg::OFS_SOURCE_RAW_VECTOR: rd_val = isr_widen(raw); // R16
            isr_pkg::OFS_SOURCE_NONSTICKY_SELECT: rd_val = isr_widen(st_r.cfg.nonsticky);
            isr_pkg::OFS_SOURCE_DETECT_MODE_LO: rd_val = st_r.cfg.mode[31:0];
            isr_pkg::OFS_SOURCE_DETECT_MODE_HI: rd_val = {16'h0000, st_r.cfg.mode[47:32]};
            isr_pkg::OFS_SOURCE_LATCHED_EVENT: rd_val = isr_widen(latched);
            isr_pkg::OFS_SOURCE_ENABLE_VECTOR: rd_val = isr_widen(st_r.cfg.enable);
            isr_pkg::OFS_SOURCE_ACTIVE_VIEW: rd_val = isr_widen(active_view);
            default: begin
                if (isr_in_dst(paddr, isr_pkg::OFS_DESTINATION_SOURCE_MASK)) begin
                    rd_val = isr_widen(
                        st_r.cfg.dmask[isr_dst_idx(paddr, isr_pkg::OFS_DESTINATION_SOURCE_MASK)*NS +: NS]);
                end else if (isr_in_dst(paddr, isr_pkg::OFS_DESTINATION_ACTIVE_VIEW)) begin
                    rd_val = isr_widen(dst_view[isr_dst_idx(paddr, isr_pkg::OFS_DESTINATION_ACTIVE_VIEW)*NS +: NS]);
                end
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.inject = '0;
        st_nxt.clear = '0;
        if (rd_en) begin
            st_nxt.rdata = rd_val;
        end
        if (wr_en) begin
            case (paddr)
                isr_pkg::OFS_SOURCE_NONSTICKY_SELECT: st_nxt.cfg.nonsticky = pwdata[NS-1:0];
                isr_pkg::OFS_SOURCE_DETECT_MODE_LO: st_nxt.cfg.mode[31:0] = pwdata;
                isr_pkg::OFS_SOURCE_DETECT_MODE_HI: st_nxt.cfg.mode[47:32] = pwdata[15:0];
                isr_pkg::OFS_SOURCE_EVENT_INJECT: st_nxt.inject = pwdata[NS-1:0]; // R17
                isr_pkg::OFS_SOURCE_LATCHED_EVENT: st_nxt.clear = pwdata[NS-1:0]; // R25
                isr_pkg::OFS_SOURCE_ENABLE_VECTOR: st_nxt.cfg.enable = pwdata[NS-1:0];
                isr_pkg::OFS_ENABLE_ATOMIC_CLEAR: st_nxt.cfg.enable = st_r.cfg.enable & ~pwdata[NS-1:0]; // R20
                isr_pkg::OFS_ENABLE_ATOMIC_SET: st_nxt.cfg.enable = st_r.cfg.enable | pwdata[NS-1:0]; // R20
                default: begin
                    if (isr_in_dst(paddr, isr_pkg::OFS_DESTINATION_SOURCE_MASK)) begin
                        st_nxt.cfg.dmask[isr_dst_idx(paddr, isr_pkg::OFS_DESTINATION_SOURCE_MASK)*NS +: NS] =
                            pwdata[NS-1:0];
                    end
                end
            endcase
        end
        for (int d = 0; d < ND; d++) begin
            st_nxt.dst_out[d] = |dst_view[d*NS +: NS]; // R22
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= '0; // R27
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_map;
    assign prdata = st_r.rdata;

    // ------------------------------------------------------------
    // destination outputs, active high; polarity handled outside
    // ------------------------------------------------------------
    assign core_irq_line_a = st_r.dst_out[isr_pkg::DST_CORE_IRQ_LINE_A]; // R2 R3
    assign core_irq_line_b = st_r.dst_out[isr_pkg::DST_CORE_IRQ_LINE_B]; // R2 R3
    assign external_output_zero = st_r.dst_out[isr_pkg::DST_EXTERNAL_OUTPUT_ZERO]; // R2 R3 R15
    assign external_output_one = st_r.dst_out[isr_pkg::DST_EXTERNAL_OUTPUT_ONE]; // R2 R3 R15

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_dst_follows;
        @(posedge core_clk) disable iff (!rst_n)
        (|dst_view[0 +: NS]) |=> core_irq_line_a;
    endproperty
    a_dst_follows: assert property (p_dst_follows) else $error("core line a not raised"); // R22

    property p_mask_gate;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.cfg.dmask[2*NS +: NS] == '0) |=> !external_output_zero;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked destination asserted"); // R26

    property p_ena_set;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_en && paddr == isr_pkg::OFS_ENABLE_ATOMIC_SET)
            |=> st_r.cfg.enable == ($past(st_r.cfg.enable) | $past(pwdata[NS-1:0]));
    endproperty
    a_ena_set: assert property (p_ena_set) else $error("atomic set wrong"); // R20

    property p_ena_clr;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_en && paddr == isr_pkg::OFS_ENABLE_ATOMIC_CLEAR)
            |=> st_r.cfg.enable == ($past(st_r.cfg.enable) & ~$past(pwdata[NS-1:0]));
    endproperty
    a_ena_clr: assert property (p_ena_clr) else $error("atomic clear wrong"); // R20

    property p_inject;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_en && paddr == isr_pkg::OFS_SOURCE_EVENT_INJECT)
            |=> ##1 ((latched & $past(pwdata[NS-1:0], 2)) == $past(pwdata[NS-1:0], 2));
    endproperty
    a_inject: assert property (p_inject) else $error("inject did not latch"); // R17

    property p_level;
        @(posedge core_clk) disable iff (!rst_n)
        (raw[3] && st_r.cfg.mode[7:6] == 2'b00) |=> latched[3];
    endproperty
    a_level: assert property (p_level) else $error("level event not latched"); // R23

    property p_bypass;
        @(posedge core_clk) disable iff (!rst_n)
        st_r.cfg.nonsticky[13] |-> active_view[13] == (raw[13] & st_r.cfg.enable[13]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not using raw"); // R19

    property p_ident;
        @(posedge core_clk) disable iff (!rst_n)
        (!st_r.cfg.nonsticky[1]) |-> active_view[1] == (latched[1] & st_r.cfg.enable[1]);
    endproperty
    a_ident: assert property (p_ident) else $error("active view mismatch"); // R21

    property p_reset;
        @(posedge core_clk)
        !rst_n |=> !core_irq_line_a && !core_irq_line_b && !external_output_zero && !external_output_one;
    endproperty
    a_reset: assert property (p_reset) else $error("destination high after reset"); // R27

    property p_dst_b;
        @(posedge core_clk) disable iff (!rst_n)
        (|dst_view[NS +: NS]) |=> core_irq_line_b;
    endproperty
    a_dst_b: assert property (p_dst_b) else $error("core line b low"); // R22

    property p_dst_one;
        @(posedge core_clk) disable iff (!rst_n)
        (|dst_view[3*NS +: NS]) |=> external_output_one;
    endproperty
    a_dst_one: assert property (p_dst_one) else $error("external one low"); // R22 R3

    property p_mask_one;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.cfg.dmask[3*NS +: NS] == '0) |=> !external_output_one;
    endproperty
    a_mask_one: assert property (p_mask_one) else $error("masked external one high"); // R26

    property p_raw_read;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_en && paddr == isr_pkg::OFS_SOURCE_RAW_VECTOR) |=> prdata == {8'h00, $past(raw)};
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("raw read wrong"); // R16

endmodule : isr_router

/* File: tb/isr_src_model.sv */
// source model: peripheral interrupt lines, active high, with optional extra latency
module isr_src_model #(
    parameter int SLOW = 0
) (
    input wire logic core_clk,
    input wire logic [isr_pkg::NUM_SRC-1:0] want,
    output logic [isr_pkg::NUM_SRC-1:0] line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [isr_pkg::NUM_SRC-1:0] hold_r = '0;
    int cnt = 0;
    // a slow peripheral takes SLOW extra cycles to move its lines
    always @(posedge core_clk) begin
        if (want !== hold_r && cnt < SLOW) begin
            cnt <= cnt + 1;
        end else begin
            hold_r <= want;
            cnt <= 0;
        end
    end
    assign line = hold_r;
endmodule : isr_src_model

/* File: tb/isr_router_tb.sv */
// testbench of the interrupt router: apb master, source model, self checks
module isr_router_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, q, seed = 32'hB485, e, x;
    logic [23:0] want = 24'h000000, src, p, es;
    logic [23:0] mk [4];
    logic pready, pslverr, o_a, o_b, o_z, o_o;
    logic [1:0] m;
    int err_total = 0, check_count = 0, k;
    wire logic [3:0] dst = {o_o, o_z, o_b, o_a};
    always #20 core_clk = ~core_clk;
    isr_src_model #(.SLOW(2)) i_src (.core_clk(core_clk), .want(want), .line(src));
    isr_router i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_module_aggregate(src[0]), .external_input_zero(src[1]), .external_input_one(src[2]),
        .timer_irq_a(src[3]), .timer_irq_b(src[4]), .timer_irq_c(src[5]), .first_serial_port_irq(src[6]),
        .second_serial_port_irq(src[7]), .two_wire_irq(src[8]), .serial_master_irq(src[9]),
        .software_irq_a(src[10]), .software_irq_b(src[11]), .serial_pin_irq(src[12]),
        .parallel_pin_irq(src[13]), .mgmt_iface_irq_a(src[14]), .mgmt_iface_irq_b(src[15]),
        .frame_dma_irq(src[16]), .frame_analyzer_irq(src[17]), .timestamp_ready_irq(src[18]),
        .time_sync_irq(src[19]), .memory_integrity_irq(src[20]), .extraction_ready_irq(src[21]),
        .injection_ready_irq(src[22]), .pcie_irq(src[23]), .core_irq_line_a(o_a), .core_irq_line_b(o_b),
        .external_output_zero(o_z), .external_output_one(o_o));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic hit(logic [1:0] md, logic a, logic b);
        case (md)
            2'b00: return b;
            2'b01: return a != b;
            2'b10: return a & ~b;
            default: return ~a & b;
        endcase
    endfunction : hit
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            complete_run;
        end
        last_err = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        idle(10);
        rst_n <= 1'b1;
        idle(2);
        chk({28'h0000000, dst}, 32'h00000000);
        for (k = 4; k < 8'h38; k += 4) rd(k[7:0], 32'h00000000);
        $display("reset test done");
        for (k = 0; k < 24; k++) begin
            want <= 24'h000001 << k;
            idle(9);
            rd(8'h00, 32'h00000001 << k);
        end
        want <= 24'h000000;
        $display("source position test done");
        for (k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            m = k[1:0];
            e = {27'h0000000, seed[4:0]} % 24;
            x = 32'h00000001 << e;
            apb(1'b1, e < 16 ? 8'h08 : 8'h0C, {30'h00000000, m} << (2 * (e % 16)));
            idle(9);
            apb(1'b1, 8'h14, 32'h00FFFFFF);
            want <= x[23:0];
            idle(9);
            es = {23'h000000, hit(m, 1'b0, 1'b1)};
            rd(8'h14, {8'h00, es} << e);
            apb(1'b1, 8'h14, x);
            idle(3);
            es = {23'h000000, m == 2'b00};
            rd(8'h14, {8'h00, es} << e);
            want <= 24'h000000;
            idle(9);
            es = es | {23'h000000, hit(m, 1'b1, 1'b0)};
            rd(8'h14, {8'h00, es} << e);
            apb(1'b1, e < 16 ? 8'h08 : 8'h0C, 32'h00000000);
        end
        $display("detect mode test done");
        apb(1'b1, 8'h14, 32'h00FFFFFF);
        apb(1'b1, 8'h10, 32'h00000400);
        idle(2);
        rd(8'h14, 32'h00000400);
        rd(8'h10, 32'h00000000);
        apb(1'b1, 8'h14, 32'h00FFFFFF);
        $display("inject test done");
        for (k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            p = seed[23:0];
            seed = lfsr(seed);
            e = {8'h00, seed[31:8]};
            want <= p;
            apb(1'b1, 8'h18, 32'h00000000);
            apb(1'b1, 8'h20, e | 32'h00000081);
            apb(1'b1, 8'h1C, 32'h00000081 & ~e);
            rd(8'h18, e);
            for (int d = 0; d < 4; d++) begin
                seed = lfsr(seed);
                mk[d] = seed[23:0];
                apb(1'b1, 8'h28 + 8'(4 * d), {8'h00, mk[d]});
            end
            idle(9);
            apb(1'b1, 8'h14, 32'h00FFFFFF);
            idle(4);
            rd(8'h24, {8'h00, p & e[23:0]});
            for (int d = 0; d < 4; d++) begin
                rd(8'h38 + 8'(4 * d), {8'h00, p & e[23:0] & mk[d]});
                chk({31'h00000000, dst[d]}, {31'h00000000, |(p & e[23:0] & mk[d])});
            end
        end
        $display("routing test done");
        want <= 24'h000000;
        apb(1'b1, 8'h18, 32'h00002000);
        apb(1'b1, 8'h28, 32'h00002000);
        apb(1'b1, 8'h04, 32'h00002000);
        want <= 24'h002000;
        idle(9);
        chk({31'h00000000, o_a}, 32'h00000001);
        want <= 24'h000000;
        idle(9);
        chk({31'h00000000, o_a}, 32'h00000000);
        $display("nonsticky test done");
        rd(8'hFC, 32'h00000000);
        chk({31'h00000000, last_err}, 32'h00000001);
        $display("unmapped test done");
        complete_run;
    end
endmodule : isr_router_tb
